// ---- design/wtsr_buf2.v ----
`timescale 1ns/1ns
// ****************************************
// Two-entry buffer, valid/ready on both sides
// ****************************************
module wtsr_buf2 #(
   parameter WIDTH = 8
) (
   core_clk,
   srst,
   in_data,
   in_valid,
   in_ready,
   out_data,
   out_valid,
   out_ready
);
   input  wire             core_clk;
   input  wire             srst;
   input  wire [WIDTH-1:0] in_data;
   input  wire             in_valid;
   output wire             in_ready;
   output wire [WIDTH-1:0] out_data;
   output wire             out_valid;
   input  wire             out_ready;

   reg  [WIDTH-1:0] mem_q [0:1];
   reg              wr_q;
   reg              rd_q;
   reg  [1:0]       cnt_q;
   wire             push;
   wire             pop;

   assign in_ready  = (cnt_q != 2'd2);
   assign out_valid = (cnt_q != 2'd0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge core_clk) begin
      if (srst) begin
         wr_q     <= 1'b0;
         rd_q     <= 1'b0;
         cnt_q    <= 2'd0;
         mem_q[0] <= {WIDTH{1'b0}};
         mem_q[1] <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            mem_q[wr_q] <= in_data;
            wr_q        <= ~wr_q;
         end
         if (pop) begin
            rd_q <= ~rd_q;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 2'd1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 2'd1;
         end
      end
   end
endmodule

// ---- design/wtsr_defs.vh ----
`ifndef WTSR_DEFS_VH
`define WTSR_DEFS_VH
// ****************************************
// Frame layout
// ****************************************
`define WTSR_START_BYTE    8'h53
`define WTSR_LEN_BYTE      8'h0B
`define WTSR_OP_BYTE       8'h1F
`define WTSR_VER_BYTE      8'h01
`define WTSR_SW_PRESSED    8'h00
`define WTSR_SW_RELEASED   8'h01
`define WTSR_FRAME_BYTES   12
// ****************************************
// Timing
// ****************************************
`define WTSR_CLK_HZ        100000000
`define WTSR_BAUD          57000
`define WTSR_BIT_CYC       (`WTSR_CLK_HZ / `WTSR_BAUD)
`define WTSR_HOLD_MS       2000
`define WTSR_IDLE_S        120
`define WTSR_MS_CYC        (`WTSR_CLK_HZ / 1000)
`define WTSR_BLINK_MS      250
`define WTSR_PULSE_MS      100
`define WTSR_LIST_DEPTH    32
`define WTSR_CHANNELS      3
`endif

// ---- design/wtsr_top.v ----
`timescale 1ns/1ns
`include "wtsr_defs.vh"
// Notes on behaviour
// - Serial link runs 57000 baud, 8 data bits, one stop, no parity.
// - Then four identifier bytes and switch state, 0x00 pressed, 0x01 released.
// - Then signal strength magnitude byte and subtelegram count byte.
// - Empty pairing list: report every transmitter, except while pairing is open.
// - Non-empty list: report only matching identifiers.
// - List holds 32 identifiers, several added per session.
// - Each stored identifier owns exactly one output function.
// - Left LED blinks when list empty, steady when not.
// - Two-second pairing button hold enters pairing, right LED blinks.
// - Short press in pairing commits; left steady, right off.
// - Two minutes without button activity abandons pairing.
// - Simple pairing gives toggle behaviour on each press.
// - Right LED blinks once per valid paired telegram.
// - Three outputs, high when active, low when inactive.
module wtsr_top #(
   parameter BIT_CYC  = `WTSR_BIT_CYC,
   parameter MS_CYC   = `WTSR_MS_CYC,
   parameter HOLD_MS  = `WTSR_HOLD_MS,
   parameter IDLE_S   = `WTSR_IDLE_S,
   parameter BLINK_MS = `WTSR_BLINK_MS,
   parameter PULSE_MS = `WTSR_PULSE_MS,
   parameter DEPTH    = `WTSR_LIST_DEPTH
) (
   core_clk,
   srst,
   rx_valid,
   rx_ready,
   rx_uid,
   rx_released,
   rx_rssi,
   rx_subtel,
   pair_btn,
   pair_func,
   txd,
   led_left_green,
   led_right_yellow,
   func_out,
   list_count
);
   input  wire        core_clk;
   input  wire        srst;
   input  wire        rx_valid;
   output wire        rx_ready;
   input  wire [31:0] rx_uid;
   input  wire        rx_released;
   input  wire [7:0]  rx_rssi;
   input  wire [7:0]  rx_subtel;
   input  wire        pair_btn;
   input  wire [1:0]  pair_func;
   output wire        txd;
   output reg         led_left_green;
   output reg         led_right_yellow;
   output reg  [2:0]  func_out;
   output reg  [5:0]  list_count;

   // ****************************************
   // Millisecond tick and button sync
   // ****************************************
   reg  [31:0] msdiv_q;
   reg         ms_tick_q;
   reg  [1:0]  btn_sync_q;
   reg  [31:0] hold_q;
   reg  [31:0] idle_q;
   reg         long_done_q;
   wire        btn;
   wire        btn_release;
   reg         btn_prev_q;

   assign btn         = btn_sync_q[1];
   assign btn_release = btn_prev_q & ~btn;

   always @(posedge core_clk) begin
      if (srst) begin
         msdiv_q    <= 32'h00000000;
         ms_tick_q  <= 1'b0;
         btn_sync_q <= 2'b00;
         btn_prev_q <= 1'b0;
      end else begin
         btn_sync_q <= {btn_sync_q[0], pair_btn};
         btn_prev_q <= btn;
         ms_tick_q  <= (msdiv_q == MS_CYC - 1);
         if (msdiv_q == MS_CYC - 1) begin
            msdiv_q <= 32'h00000000;
         end else begin
            msdiv_q <= msdiv_q + 32'd1;
         end
      end
   end

   // ****************************************
   // Pairing list
   // ****************************************
   reg  [31:0] uid_q  [0:DEPTH-1];
   reg  [1:0]  fn_q   [0:DEPTH-1];
   reg         pairing_q;
   reg  [5:0]  pend_q;
   wire [DEPTH-1:0] hit_vec;
   reg  [4:0]  hit_idx;
   reg         hit;
   reg         pend_hit;
   integer     k;
   integer     m;

   genvar g;
   generate
      for (g = 0; g < DEPTH; g = g + 1) begin : g_cmp
         assign hit_vec[g] = (g < list_count) && (uid_q[g] == rx_uid);
      end
   endgenerate

   always @* begin
      hit     = 1'b0;
      hit_idx = 5'd0;
      for (k = 0; k < DEPTH; k = k + 1) begin
         if (hit_vec[k] && !hit) begin
            hit     = 1'b1;
            hit_idx = k[4:0];
         end
      end
   end

   // Commit makes the pending entries permanent; abandon discards them
   wire commit  = pairing_q & btn_release & ~long_done_q;
   wire abandon = pairing_q & ms_tick_q & (idle_q >= IDLE_S * 1000 - 1);

   always @(posedge core_clk) begin
      if (srst) begin
         hold_q      <= 32'h00000000;
         idle_q      <= 32'h00000000;
         long_done_q <= 1'b0;
         pairing_q   <= 1'b0;
         pend_q      <= 6'd0;
         list_count  <= 6'd0;
      end else begin
         if (btn) begin
            idle_q <= 32'h00000000;
            if (ms_tick_q && !long_done_q) begin
               hold_q <= hold_q + 32'd1;
               if (hold_q >= HOLD_MS - 1) begin
                  long_done_q <= 1'b1;
                  if (!pairing_q) begin
                     pairing_q <= 1'b1;
                     pend_q    <= list_count;
                  end
               end
            end
         end else begin
            hold_q      <= 32'h00000000;
            long_done_q <= 1'b0;
            if (ms_tick_q && pairing_q) begin
               idle_q <= idle_q + 32'd1;
            end
         end
         if (commit) begin
            pairing_q  <= 1'b0;
            list_count <= pend_q;
         end else if (abandon) begin
            pairing_q <= 1'b0;
            idle_q    <= 32'h00000000;
         end else if (pairing_q && rx_valid && rx_ready && !pend_hit
                      && pend_q < DEPTH) begin
            pend_q <= pend_q + 6'd1;
         end
      end
   end

   // Capture during pairing; an identifier already listed keeps its one function
   always @* begin
      pend_hit = 1'b0;
      for (m = 0; m < DEPTH; m = m + 1) begin
         if ((m < pend_q) && (uid_q[m] == rx_uid)) begin
            pend_hit = 1'b1;
         end
      end
   end

   always @(posedge core_clk) begin
      if (pairing_q && rx_valid && rx_ready && !pend_hit && pend_q < DEPTH) begin
         uid_q[pend_q[4:0]] <= rx_uid;
         fn_q[pend_q[4:0]]  <= (pair_func == 2'd0) ? 2'd0 : pair_func - 2'd1;
      end
   end

   // ****************************************
   // Report filter and outputs
   // ****************************************
   wire pass      = (list_count == 6'd0) | hit;
   wire start_frm;
   reg  [3:0]  idx_q;
   reg         busy_q;
   reg  [31:0] f_uid_q;
   reg  [7:0]  f_sw_q;
   reg  [7:0]  f_rssi_q;
   reg  [7:0]  f_sub_q;
   reg  [7:0]  csum_q;
   reg  [31:0] pulse_q;

   // Telegrams wait while a frame is still being built, so none is dropped
   assign rx_ready  = ~busy_q;
   assign start_frm = rx_valid & ~busy_q & ~pairing_q & pass;

   always @(posedge core_clk) begin
      if (srst) begin
         func_out <= 3'b000;
         pulse_q  <= 32'h00000000;
      end else begin
         if (rx_valid && rx_ready && !pairing_q && hit && !rx_released) begin
            func_out[fn_q[hit_idx]] <= ~func_out[fn_q[hit_idx]];
         end
         if (rx_valid && rx_ready && !pairing_q && hit) begin
            pulse_q <= PULSE_MS;
         end else if (ms_tick_q && pulse_q != 0) begin
            pulse_q <= pulse_q - 32'd1;
         end
      end
   end

   // ****************************************
   // LEDs
   // ****************************************
   reg [31:0] blink_q;
   reg        blink_ph_q;
   always @(posedge core_clk) begin
      if (srst) begin
         blink_q          <= 32'h00000000;
         blink_ph_q       <= 1'b0;
         led_left_green   <= 1'b0;
         led_right_yellow <= 1'b0;
      end else begin
         if (ms_tick_q) begin
            if (blink_q >= BLINK_MS - 1) begin
               blink_q    <= 32'h00000000;
               blink_ph_q <= ~blink_ph_q;
            end else begin
               blink_q <= blink_q + 32'd1;
            end
         end
         led_left_green   <= (list_count == 6'd0) ? blink_ph_q : 1'b1;
         led_right_yellow <= pairing_q ? blink_ph_q : (pulse_q != 0);
      end
   end

   // ****************************************
   // Frame builder into buffer
   // ****************************************
   reg  [7:0] byte_d;
   wire       b_ready;
   wire [7:0] q_data;
   wire       q_valid;
   wire       q_ready;

   always @* begin
      case (idx_q)
         4'd0:    byte_d = `WTSR_START_BYTE;
         4'd1:    byte_d = `WTSR_LEN_BYTE;
         4'd2:    byte_d = `WTSR_OP_BYTE;
         4'd3:    byte_d = `WTSR_VER_BYTE;
         4'd4:    byte_d = f_uid_q[31:24];
         4'd5:    byte_d = f_uid_q[23:16];
         4'd6:    byte_d = f_uid_q[15:8];
         4'd7:    byte_d = f_uid_q[7:0];
         4'd8:    byte_d = f_sw_q;
         4'd9:    byte_d = f_rssi_q;
         4'd10:   byte_d = f_sub_q;
         4'd11:   byte_d = csum_q;
         default: byte_d = 8'h00;
      endcase
   end

   always @(posedge core_clk) begin
      if (srst) begin
         busy_q   <= 1'b0;
         idx_q    <= 4'h0;
         csum_q   <= 8'h00;
         f_uid_q  <= 32'h00000000;
         f_sw_q   <= 8'h00;
         f_rssi_q <= 8'h00;
         f_sub_q  <= 8'h00;
      end else if (!busy_q) begin
         if (start_frm) begin
            busy_q   <= 1'b1;
            idx_q    <= 4'h0;
            csum_q   <= 8'h00;
            f_uid_q  <= rx_uid;
            f_sw_q   <= rx_released ? `WTSR_SW_RELEASED : `WTSR_SW_PRESSED;
            f_rssi_q <= rx_rssi;
            f_sub_q  <= rx_subtel;
         end
      end else if (b_ready) begin
         csum_q <= csum_q ^ byte_d;
         if (idx_q == `WTSR_FRAME_BYTES - 1) begin
            busy_q <= 1'b0;
         end
         idx_q <= idx_q + 4'h1;
      end
   end

   wtsr_buf2 #(.WIDTH(8)) u_buf (
      .core_clk  (core_clk),
      .srst      (srst),
      .in_data   (byte_d),
      .in_valid  (busy_q),
      .in_ready  (b_ready),
      .out_data  (q_data),
      .out_valid (q_valid),
      .out_ready (q_ready)
   );

   wtsr_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
      .core_clk (core_clk),
      .srst     (srst),
      .tx_data  (q_data),
      .tx_valid (q_valid),
      .tx_ready (q_ready),
      .txd      (txd)
   );
endmodule

// ---- design/wtsr_uart_tx.v ----
`timescale 1ns/1ns
`include "wtsr_defs.vh"
// ****************************************
// Serial transmitter, 8N1, LSB first
// ****************************************
module wtsr_uart_tx #(
   parameter BIT_CYC = `WTSR_BIT_CYC
) (
   core_clk,
   srst,
   tx_data,
   tx_valid,
   tx_ready,
   txd
);
   input  wire       core_clk;
   input  wire       srst;
   input  wire [7:0] tx_data;
   input  wire       tx_valid;
   output wire       tx_ready;
   output reg        txd;

   reg  [15:0] div_q;
   reg  [3:0]  bit_q;
   reg  [9:0]  sh_q;
   reg         busy_q;
   wire        tick;

   assign tick     = (div_q == BIT_CYC[15:0] - 16'd1);
   assign tx_ready = ~busy_q;

   always @(posedge core_clk) begin
      if (srst) begin
         div_q  <= 16'h0000;
         bit_q  <= 4'h0;
         sh_q   <= 10'h3FF;
         busy_q <= 1'b0;
         txd    <= 1'b1;
      end else if (!busy_q) begin
         txd <= 1'b1;
         if (tx_valid) begin
            sh_q   <= {1'b1, tx_data, 1'b0};
            busy_q <= 1'b1;
            div_q  <= 16'h0000;
            bit_q  <= 4'h0;
         end
      end else begin
         txd <= sh_q[0];
         if (tick) begin
            div_q <= 16'h0000;
            sh_q  <= {1'b1, sh_q[9:1]};
            if (bit_q == 4'd9) begin
               busy_q <= 1'b0;
            end
            bit_q <= bit_q + 4'd1;
         end else begin
            div_q <= div_q + 16'd1;
         end
      end
   end
endmodule

// ---- test/wtsr_host_rx.sv ----
`timescale 1ns/1ns
module wtsr_host_rx #(
   parameter BIT_CYC = 4
) (
   input wire logic core_clk,
   input wire logic txd
);
   logic [7:0] q[$];
   int         errs = 0;
   // Samples mid-bit; a missing stop bit is a framing fault
   initial begin
      logic [7:0] b;
      forever begin
         @(negedge txd);
         repeat (BIT_CYC / 2) @(posedge core_clk);
         if (txd !== 1'b0) errs++;
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge core_clk);
            b[i] = txd;
         end
         repeat (BIT_CYC) @(posedge core_clk);
         if (txd !== 1'b1) errs++;
         q.push_back(b);
      end
   end
endmodule

// ---- test/wtsr_top_assertions.sv ----
`timescale 1ns/1ns
module wtsr_top_assertions #(
   parameter BIT_CYC  = 4,
   parameter MS_CYC   = 10,
   parameter BLINK_MS = 250,
   parameter DEPTH    = 32
) (
   input wire logic       core_clk,
   input wire logic       srst,
   input wire logic       rx_valid,
   input wire logic       rx_ready,
   input wire logic       txd,
   input wire logic       led_left_green,
   input wire logic       led_right_yellow,
   input wire logic [2:0] func_out,
   input wire logic [5:0] list_count
);
   // ****************************************
   // Helper counters
   // ****************************************
   // A take may queue a whole frame behind three bytes still in flight
   localparam int IDLE_CYC = 16 * (10 * BIT_CYC + 1) + 40;
   int quiet_q;
   int still_q;
   always @(posedge core_clk) begin
      if (srst || (rx_valid && rx_ready)) quiet_q <= 0;
      else if (quiet_q < IDLE_CYC) quiet_q <= quiet_q + 1;
      // Any stored entry ends the blink duty, so the counter restarts
      if (srst || list_count != 6'h00 || $changed(led_left_green)) still_q <= 0;
      else still_q <= still_q + 1;
   end
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   chk_build_busy: assert property ($fell(rx_ready) |-> (!rx_ready) [*8])
      else $error("ready returned during frame build");
   chk_ready_back: assert property ($fell(rx_ready) |-> ##[1:1000] rx_ready)
      else $error("ready stuck low");
   chk_low_width: assert property ($fell(txd) |-> (!txd) [*4])
      else $error("low bit shorter than one bit time");
   chk_high_width: assert property ($rose(txd) |-> txd [*4])
      else $error("high bit shorter than one bit time");
   chk_idle_high: assert property (quiet_q >= IDLE_CYC |-> txd)
      else $error("serial line not idle high");
   chk_list_max: assert property (list_count <= DEPTH)
      else $error("list count above depth");
   chk_left_steady: assert property ((list_count != 6'h00) [*2] |-> led_left_green)
      else $error("left indicator not steady with entries");
   chk_left_blink: assert property (still_q <= BLINK_MS * MS_CYC + 2)
      else $error("left indicator not blinking on empty list");
   chk_func_cause: assert property (!$stable(func_out) |-> $past(list_count) != 6'h00)
      else $error("output moved with empty list");
   cov_take: cover property (rx_valid && rx_ready);
   cov_commit: cover property ($rose(list_count != 6'h00));
   cov_pair_led: cover property ($rose(led_right_yellow));
   cov_func: cover property (!$stable(func_out));
endmodule

bind wtsr_top wtsr_top_assertions #(
   .BIT_CYC  (BIT_CYC),
   .MS_CYC   (MS_CYC),
   .BLINK_MS (BLINK_MS),
   .DEPTH    (DEPTH)
) u_chk (
   .core_clk         (core_clk),
   .srst             (srst),
   .rx_valid         (rx_valid),
   .rx_ready         (rx_ready),
   .txd              (txd),
   .led_left_green   (led_left_green),
   .led_right_yellow (led_right_yellow),
   .func_out         (func_out),
   .list_count       (list_count)
);

// ---- test/wtsr_top_bench.sv ----
`timescale 1ns/1ns
module wtsr_top_bench;
   logic        core_clk = 0, srst = 1, rx_valid = 0, rx_released = 0, pair_btn = 0;
   logic [31:0] rx_uid = 32'h0;
   logic [7:0]  rx_rssi = 8'h00, rx_subtel = 8'h00;
   logic [1:0]  pair_func = 2'h2;
   wire         rx_ready, txd, led_left_green, led_right_yellow;
   wire  [2:0]  func_out;
   wire  [5:0]  list_count;
   int          bad_count = 0, samples_checked = 0, n;
   always #5 core_clk = ~core_clk;
   // Short timings keep the run well inside the cycle budget
   localparam int BITC = 4, MSC = 10, HOLDMS = 3, IDLES = 1, BLINKMS = 5;
   wtsr_top #(.BIT_CYC(BITC), .MS_CYC(MSC), .HOLD_MS(HOLDMS), .IDLE_S(IDLES),
      .BLINK_MS(BLINKMS)) u_dut (
      .core_clk(core_clk), .srst(srst), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_uid(rx_uid), .rx_released(rx_released), .rx_rssi(rx_rssi),
      .rx_subtel(rx_subtel), .pair_btn(pair_btn), .pair_func(pair_func), .txd(txd),
      .led_left_green(led_left_green), .led_right_yellow(led_right_yellow),
      .func_out(func_out), .list_count(list_count));
   wtsr_host_rx u_host (.core_clk(core_clk), .txd(txd));
   // ****************************************
   // Shared tasks
   // ****************************************
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task send(input logic [31:0] transmitter_unique_id, input logic rel, input logic [7:0] rssi, sub);
      @(posedge core_clk); #1;
      {rx_uid, rx_released, rx_rssi, rx_subtel, rx_valid} = {transmitter_unique_id, rel, rssi, sub, 1'b1};
      n = 0;
      do begin @(negedge core_clk); n++; end while (rx_ready !== 1'b1 && n < 2000);
      if (n >= 2000) begin bad_count++; wrap_up; end
      @(posedge core_clk); #1 rx_valid = 0;
   endtask
   task expect_frame(input logic [31:0] transmitter_unique_id, input logic rel, input logic [7:0] rssi, sub);
      logic [7:0] e[12];
      logic [7:0] x;
      e = '{8'h53, 8'h0B, 8'h1F, 8'h01, transmitter_unique_id[31:24], transmitter_unique_id[23:16], transmitter_unique_id[15:8], transmitter_unique_id[7:0],
            {7'h00, rel}, rssi, sub, 8'h00};
      x = 8'h00;
      for (int i = 0; i < 11; i++) x ^= e[i];
      e[11] = x;
      n = 0;
      while (u_host.q.size() < 12 && n < 5000) begin @(posedge core_clk); n++; end
      if (n >= 5000) begin bad_count++; wrap_up; end
      check(u_host.q.size() >= 12, 1);
      for (int i = 0; i < 12; i++) check(u_host.q.pop_front(), e[i]);
   endtask
   task expect_none;
      repeat (700) @(posedge core_clk);
      check(u_host.q.size(), 0);
   endtask
   task press(input int cyc);
      @(posedge core_clk); #1 pair_btn = 1;
      repeat (cyc) @(posedge core_clk);
      #1 pair_btn = 0;
      repeat (10) @(posedge core_clk);
   endtask
   task wait_pulse;
      n = 0;
      while (led_right_yellow !== 1'b1 && n < 300) begin @(posedge core_clk); #1; n++; end
      check(led_right_yellow, 1);
      if (n >= 300) wrap_up;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task t_reset;
      repeat (4) @(posedge core_clk);
      #1 srst = 0;
      check({txd, rx_ready, func_out, list_count}, {2'b11, 9'h000});
      n = 0;
      while (led_left_green !== 1'b1 && n < 200) begin @(posedge core_clk); #1; n++; end
      check(led_left_green, 1);
      if (n >= 200) wrap_up;
   endtask
   task t_open;
      send(32'hA1B2C3D4, 0, 8'h3C, 8'h03);
      send(32'h11223344, 1, 8'h50, 8'h02);
      expect_frame(32'hA1B2C3D4, 0, 8'h3C, 8'h03);
      expect_frame(32'h11223344, 1, 8'h50, 8'h02);
   endtask
   task t_pair;
      press(60);
      wait_pulse;
      send(32'hA1B2C3D4, 0, 8'h20, 8'h01);
      // Second entry goes to the third channel
      pair_func = 2'h3;
      send(32'h11223344, 0, 8'h20, 8'h01);
      expect_none;
      press(5);
      repeat (20) @(posedge core_clk);
      check(list_count, 2);
      check({led_left_green, led_right_yellow}, 2'b10);
   endtask
   task t_filter;
      send(32'h55667788, 0, 8'h40, 8'h01);
      expect_none;
      send(32'hA1B2C3D4, 0, 8'h41, 8'h02);
      wait_pulse;
      expect_frame(32'hA1B2C3D4, 0, 8'h41, 8'h02);
      check(func_out, 3'b010);
      send(32'hA1B2C3D4, 1, 8'h42, 8'h03);
      expect_frame(32'hA1B2C3D4, 1, 8'h42, 8'h03);
      check(func_out, 3'b010);
      send(32'hA1B2C3D4, 0, 8'h43, 8'h01);
      expect_frame(32'hA1B2C3D4, 0, 8'h43, 8'h01);
      check(func_out, 3'b000);
      send(32'h11223344, 0, 8'h44, 8'h02);
      expect_frame(32'h11223344, 0, 8'h44, 8'h02);
      check(func_out, 3'b100);
   endtask
   task t_abandon;
      press(60);
      repeat (10300) @(posedge core_clk);
      send(32'h0BADF00D, 0, 8'h30, 8'h01);
      expect_none;
      check(list_count, 2);
      check(led_right_yellow, 0);
      // Had pairing stayed open, this press would commit the third identifier
      press(5);
      check(list_count, 2);
   endtask
   initial begin
      t_reset;
      t_open;
      t_pair;
      t_filter;
      t_abandon;
      check(u_host.errs, 0);
      wrap_up;
   end
   initial begin
      #1000000;
      bad_count++;
      wrap_up;
   end
endmodule
